// *** core/irq_out_pkg.sv ***
// Constants for the host interrupt output controller
package irq_out_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_DEVICE_IDENTITY = 8'h50;
  localparam logic [7:0] OFS_IRQ_CONFIG      = 8'h54;
  localparam logic [7:0] OFS_IRQ_STATUS      = 8'h58;
  localparam logic [7:0] OFS_IRQ_ENABLE      = 8'h5C;

  // Output configuration fields
  localparam int unsigned CFG_INTERVAL_LSB = 24;
  localparam int unsigned CFG_INTERVAL_MSB = 31;
  localparam int unsigned CFG_CLEAR_BIT    = 14;
  localparam int unsigned CFG_ACTIVE_BIT   = 13;
  localparam int unsigned CFG_MASTER_BIT   = 12;
  localparam int unsigned CFG_ENABLE_BIT   = 8;
  localparam int unsigned CFG_POLARITY_BIT = 4;
  localparam int unsigned CFG_BUFFER_BIT   = 0;

  // Status bit of the power management event
  localparam int unsigned POWER_EVENT_BIT = 17;

  // Reset values
  localparam logic [31:0] RST_IRQ_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_ENABLE = 32'h0000_0000;
  localparam logic [7:0]  RST_INTERVAL   = 8'h00;
  localparam logic        RST_ENABLE     = 1'b0;
  localparam logic        RST_POLARITY   = 1'b0;
  localparam logic        RST_BUFFER     = 1'b0;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

  // Identification, values arbitrary
  localparam logic [15:0] IDENT_DEVICE   = 16'hA5C3;
  localparam logic [15:0] IDENT_REVISION = 16'h0001;

  // Timing
  localparam int unsigned CLOCK_PERIOD_NS   = 10;
  localparam int unsigned INTERVAL_UNIT_NS  = 10000;
  localparam int unsigned INTERVAL_UNIT_CYC =
    (INTERVAL_UNIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage : irq_out_pkg

// *** core/deassert_timer.sv ***
// Deassertion interval timer counted in fixed time units
`timescale 1ns/1ps
`default_nettype none

module deassert_timer #(
  parameter int unsigned UNIT_CYCLES = irq_out_pkg::INTERVAL_UNIT_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       restart,
  input  wire logic       halt,
  input  wire logic [7:0] length,
  output logic            active
);

  logic [15:0] pre_q;
  logic [15:0] pre_d;
  logic [7:0]  units_q;
  logic [7:0]  units_d;
  logic        active_q;
  logic        active_d;

  always_comb
  begin
    pre_d    = pre_q;
    units_d  = units_q;
    active_d = active_q;
    if (halt)
    begin
      // Disabled: counter reset, nothing held back
      pre_d    = 16'h0000;
      units_d  = 8'h00;
      active_d = 1'b0;
    end
    else if (restart)
    begin
      // Length sampled at each start, so a new value applies next time
      pre_d    = 16'h0000;
      units_d  = length;
      active_d = (length != 8'h00);
    end
    else if (active_q)
    begin
      if (pre_q == 16'(UNIT_CYCLES - 1))
      begin
        pre_d = 16'h0000;
        if (units_q <= 8'h01)
        begin
          units_d  = 8'h00;
          active_d = 1'b0;
        end
        else
        begin
          units_d = units_q - 8'h01;
        end
      end
      else
      begin
        pre_d = pre_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q    <= 16'h0000;
      units_q  <= 8'h00;
      active_q <= 1'b0;
    end
    else
    begin
      pre_q    <= pre_d;
      units_q  <= units_d;
      active_q <= active_d;
    end
  end

  assign active = active_q;

endmodule : deassert_timer

`default_nettype wire

// *** core/host_interrupt_output_control.sv ***
// Host interrupt output controller with deassertion interval
`timescale 1ns/1ps
`default_nettype none

// Function
// - Eight-bit deassertion interval in config bits 31:24, units of 10 us.
// - Interval zero disables function, resets counter, releases pending interrupts.
// - New non-zero interval length applies to interrupts occurring afterwards.
// - Power event interrupt is never held back by the interval.
// - Writing one to clear bit restarts the deassertion interval.
// - Active bit set during interval; output withheld; clears itself at end.
// - Master bit shows internal request, ignoring enable and interval.
// - Output enable clear holds pin deasserted; status bits unaffected.
// - Polarity zero gives active-low output, one gives active-high.
// - Buffer type zero is open-drain, one is push-pull.
// - Open-drain output ignores polarity and is always active low.
// - Read-only identity: device code high half, revision low half.
// - Polarity and buffer type survive software reset.
// - Writing one to a status bit clears it; zero leaves it.
module host_interrupt_output_control #(
  parameter int unsigned UNIT_CYCLES = irq_out_pkg::INTERVAL_UNIT_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        software_reset,
  input  wire logic [31:0] interrupt_events,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             irq_pin_out,
  output logic             irq_pin_oe
);

  // Reset release through two flip-flops
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync_q;

  // Address decode
  logic wr_config;
  logic wr_status;
  logic wr_enable;

  always_comb
  begin
    wr_config = reg_write && (reg_addr == irq_out_pkg::OFS_IRQ_CONFIG);
    wr_status = reg_write && (reg_addr == irq_out_pkg::OFS_IRQ_STATUS);
    wr_enable = reg_write && (reg_addr == irq_out_pkg::OFS_IRQ_ENABLE);
  end

  // Configuration cleared by any reset
  logic [7:0] deassert_interval_q;
  logic [7:0] deassert_interval_d;
  logic       output_enable_q;
  logic       output_enable_d;
  logic       deassert_interval_clear;

  always_comb
  begin
    deassert_interval_d     = deassert_interval_q;
    output_enable_d         = output_enable_q;
    deassert_interval_clear = 1'b0;
    if (software_reset)
    begin
      deassert_interval_d = irq_out_pkg::RST_INTERVAL;
      output_enable_d     = irq_out_pkg::RST_ENABLE;
    end
    else if (wr_config)
    begin
      deassert_interval_d = reg_wdata[irq_out_pkg::CFG_INTERVAL_MSB:
                                      irq_out_pkg::CFG_INTERVAL_LSB];
      output_enable_d     = reg_wdata[irq_out_pkg::CFG_ENABLE_BIT];
      // Self-clearing strobe, never stored
      deassert_interval_clear = reg_wdata[irq_out_pkg::CFG_CLEAR_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deassert_interval_q <= irq_out_pkg::RST_INTERVAL;
      output_enable_q     <= irq_out_pkg::RST_ENABLE;
    end
    else
    begin
      deassert_interval_q <= deassert_interval_d;
      output_enable_q     <= output_enable_d;
    end
  end

  // Pin configuration kept through software reset
  logic output_polarity_q;
  logic output_polarity_d;
  logic push_pull_q;
  logic push_pull_d;

  always_comb
  begin
    output_polarity_d = output_polarity_q;
    push_pull_d       = push_pull_q;
    // Software reset deliberately not looked at here
    if (wr_config)
    begin
      output_polarity_d = reg_wdata[irq_out_pkg::CFG_POLARITY_BIT];
      push_pull_d       = reg_wdata[irq_out_pkg::CFG_BUFFER_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      output_polarity_q <= irq_out_pkg::RST_POLARITY;
      push_pull_q       <= irq_out_pkg::RST_BUFFER;
    end
    else
    begin
      output_polarity_q <= output_polarity_d;
      push_pull_q       <= push_pull_d;
    end
  end

  // Status and enable
  logic [31:0] interrupt_status_q;
  logic [31:0] interrupt_status_d;
  logic [31:0] interrupt_enable_q;
  logic [31:0] interrupt_enable_d;

  always_comb
  begin
    interrupt_status_d = interrupt_status_q;
    interrupt_enable_d = interrupt_enable_q;
    if (software_reset)
    begin
      interrupt_status_d = irq_out_pkg::RST_IRQ_STATUS;
      interrupt_enable_d = irq_out_pkg::RST_IRQ_ENABLE;
    end
    else
    begin
      if (wr_status)
      begin
        interrupt_status_d = interrupt_status_q & ~reg_wdata;
      end
      // Set after clear so an event in the clearing cycle is kept
      interrupt_status_d = interrupt_status_d | interrupt_events;
      if (wr_enable)
      begin
        interrupt_enable_d = reg_wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interrupt_status_q <= irq_out_pkg::RST_IRQ_STATUS;
      interrupt_enable_q <= irq_out_pkg::RST_IRQ_ENABLE;
    end
    else
    begin
      interrupt_status_q <= interrupt_status_d;
      interrupt_enable_q <= interrupt_enable_d;
    end
  end

  // Request combining
  logic [31:0] pending;
  logic        internal_request;
  logic        power_event_request;
  logic        other_request;

  always_comb
  begin
    pending             = interrupt_status_q & interrupt_enable_q;
    internal_request    = |pending;
    power_event_request = pending[irq_out_pkg::POWER_EVENT_BIT];
    other_request       = |(pending & ~(32'h0000_0001 << irq_out_pkg::POWER_EVENT_BIT));
  end

  // Deassertion interval
  logic deassert_interval_active;
  logic interval_restart;
  logic interval_halt;
  logic irq_asserted_q;
  logic irq_asserted_d;

  always_comb
  begin
    // Zero length or software reset: counter held reset; at zero length pending goes out
    interval_halt = software_reset || (deassert_interval_q == 8'h00);
    irq_asserted_d = output_enable_q &&
      (power_event_request ||
       (other_request && !deassert_interval_active));
    // Falling output starts a fresh interval, as does the clear strobe
    interval_restart = (irq_asserted_q && !irq_asserted_d) ||
                       deassert_interval_clear;
  end

  deassert_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_deassert_timer (
    .clock   (clock),
    .rst_n   (rst_n),
    .restart (interval_restart),
    .halt    (interval_halt),
    .length  (deassert_interval_q),
    .active  (deassert_interval_active)
  );

  // Pin drive
  logic irq_pin_out_q;
  logic irq_pin_out_d;
  logic irq_pin_oe_q;
  logic irq_pin_oe_d;

  always_comb
  begin
    if (push_pull_q)
    begin
      irq_pin_oe_d  = 1'b1;
      irq_pin_out_d = output_polarity_q ? irq_asserted_d : !irq_asserted_d;
    end
    else
    begin
      // Open drain only ever pulls low, polarity ignored
      irq_pin_oe_d  = irq_asserted_d;
      irq_pin_out_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_asserted_q <= 1'b0;
      irq_pin_out_q  <= 1'b0;
      irq_pin_oe_q   <= 1'b0;
    end
    else
    begin
      irq_asserted_q <= irq_asserted_d;
      irq_pin_out_q  <= irq_pin_out_d;
      irq_pin_oe_q   <= irq_pin_oe_d;
    end
  end

  assign irq_pin_out = irq_pin_out_q;
  assign irq_pin_oe  = irq_pin_oe_q;

  // Read path
  logic [31:0] reg_rdata_q;
  logic [31:0] reg_rdata_d;
  logic [31:0] config_view;

  always_comb
  begin
    config_view = irq_out_pkg::READ_ZERO;
    config_view[irq_out_pkg::CFG_INTERVAL_MSB:irq_out_pkg::CFG_INTERVAL_LSB] =
      deassert_interval_q;
    config_view[irq_out_pkg::CFG_ACTIVE_BIT]   = deassert_interval_active;
    config_view[irq_out_pkg::CFG_MASTER_BIT]   = internal_request;
    config_view[irq_out_pkg::CFG_ENABLE_BIT]   = output_enable_q;
    config_view[irq_out_pkg::CFG_POLARITY_BIT] = output_polarity_q;
    config_view[irq_out_pkg::CFG_BUFFER_BIT]   = push_pull_q;
    reg_rdata_d = reg_rdata_q;
    if (reg_read)
    begin
      unique case (reg_addr)
        irq_out_pkg::OFS_DEVICE_IDENTITY:
          reg_rdata_d = {irq_out_pkg::IDENT_DEVICE, irq_out_pkg::IDENT_REVISION};
        irq_out_pkg::OFS_IRQ_CONFIG: reg_rdata_d = config_view;
        irq_out_pkg::OFS_IRQ_STATUS: reg_rdata_d = interrupt_status_q;
        irq_out_pkg::OFS_IRQ_ENABLE: reg_rdata_d = interrupt_enable_q;
        default:                     reg_rdata_d = irq_out_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= irq_out_pkg::READ_ZERO;
    end
    else
    begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule : host_interrupt_output_control

`default_nettype wire

// *** dv/irq_out_checker.sv ***
// Port-level assertions for the host interrupt output controller
`timescale 1ns/1ps
`default_nettype none
module irq_out_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        software_reset,
  input wire logic [31:0] interrupt_events,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq_pin_out,
  input wire logic        irq_pin_oe
);
  logic       buf_q, pol_q, en_q, buf_d, pol_d, en_d, cw;
  logic [7:0] iv_q, iv_d;
  // Config shadow; soft reset spares buffer and polarity
  always_comb
  begin
    cw    = reg_write && reg_addr == 8'h54;
    buf_d = cw ? reg_wdata[0] : buf_q;
    pol_d = cw ? reg_wdata[4] : pol_q;
    en_d  = software_reset ? 1'b0 : (cw ? reg_wdata[8] : en_q);
    iv_d  = software_reset ? 8'h00 : (cw ? reg_wdata[31:24] : iv_q);
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      {buf_q, pol_q, en_q, iv_q} <= 11'h000;
    else
      {buf_q, pol_q, en_q, iv_q} <= {buf_d, pol_d, en_d, iv_d};
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  property p_ident;
    reg_read && reg_addr == 8'h50 |=>
      reg_rdata == {irq_out_pkg::IDENT_DEVICE, irq_out_pkg::IDENT_REVISION};
  endproperty
  a_ident: assert property (p_ident) else $error("identity read wrong");
  property p_cfg_rd;
    reg_read && reg_addr == 8'h54 |=> reg_rdata[31:24] == $past(iv_q) && !reg_rdata[14]
      && reg_rdata[8] == $past(en_q);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_deas_off;
    reg_read && reg_addr == 8'h54 && iv_q == 8'h00 && $past(iv_q) == 8'h00 |=> !reg_rdata[13];
  endproperty
  a_deas_off: assert property (p_deas_off) else $error("interval active while off");
  property p_w1c;
    reg_write && reg_addr == 8'h58 ##0 (interrupt_events == 32'h0) [*3] ##0
      reg_read && reg_addr == 8'h58 |=> (reg_rdata & $past(reg_wdata, 3)) == 32'h0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");
  property p_od_low;
    !buf_q && !$past(buf_q) |-> !irq_pin_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drives high");
  property p_pp_oe;
    buf_q && $past(buf_q) |-> irq_pin_oe;
  endproperty
  a_pp_oe: assert property (p_pp_oe) else $error("push-pull not driving");
  property p_off;
    !en_q && !$past(en_q) && $stable(pol_q) && $stable(buf_q) |->
      (buf_q ? irq_pin_out == !pol_q : !irq_pin_oe);
  endproperty
  a_off: assert property (p_off) else $error("disabled pin asserted");
  property p_soft_keep;
    software_reset && buf_q |=> irq_pin_oe [*2];
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("buffer type lost");
endmodule : irq_out_checker
`default_nettype wire

// *** dv/host_bus_model.sv ***
// Host processor model on the register strobe bus
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic        clock,
  input  wire logic [31:0] reg_rdata,
  output logic      [7:0]  reg_addr  = 8'h00,
  output logic             reg_write = 1'b0,
  output logic             reg_read  = 1'b0,
  output logic      [31:0] reg_wdata = 32'h0
);
  int unsigned gap = 0;
  // Acknowledge is a write of ones to status bits
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Released lines show junk, not the last word
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata;
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// *** dv/tb_host_interrupt_output_control.sv ***
// Self-checking bench for the host interrupt output controller
`timescale 1ns/1ps
`default_nettype none
module tb_host_interrupt_output_control;
  localparam int          U  = 10;
  localparam logic [31:0] ID = {irq_out_pkg::IDENT_DEVICE, irq_out_pkg::IDENT_REVISION};
  logic        clock            = 1'b0;
  logic        nrst             = 1'b0;
  logic        software_reset   = 1'b0;
  logic [31:0] interrupt_events = 32'h0;
  logic [7:0]  reg_addr;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        irq_pin_out;
  logic        irq_pin_oe;
  logic [31:0] d;
  int          mismatches = 0;
  int          n_checks   = 0;
  int          st, ie, cf, n;
  always #5 clock = ~clock;
  host_interrupt_output_control #(.UNIT_CYCLES(U)) i_host_interrupt_output_control (
    .clock, .nrst, .software_reset, .interrupt_events, .reg_addr, .reg_write,
    .reg_read, .reg_wdata, .reg_rdata, .irq_pin_out, .irq_pin_oe);
  host_bus_model i_host_bus_model (.clock, .reg_rdata, .reg_addr, .reg_write, .reg_read,
    .reg_wdata);
  task automatic fail(input string s);
    mismatches++;
    $display("CHECK FAILED %0t %s", $time, s);
  endtask : fail
  task automatic wr(input logic [7:0] a, input int v);
    i_host_bus_model.wr(a, v);
    if (a == 8'h58)
      st &= ~v;
    if (a == 8'h5C)
      ie = v;
    if (a == 8'h54)
      cf = v & 32'hFF00_0111;
  endtask : wr
  task automatic ev(input int m);
    @(posedge clock);
    interrupt_events <= m;
    @(posedge clock);
    interrupt_events <= 32'h0;
    st |= m;
  endtask : ev
  function automatic int cfx();
    return cf | (int'((st & ie) != 0) << 12);
  endfunction : cfx
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    i_host_bus_model.rd(a, d);
    n_checks++;
    if (d !== e)
      fail($sformatf("read %h got %h exp %h", a, d, e));
  endtask : chk_reg
  task automatic chk_pin(input bit a);
    repeat (2) @(posedge clock);
    #1;
    n_checks++;
    if ({irq_pin_out, irq_pin_oe} !== (cf[0] ? {a == cf[4], 1'b1} : {1'b0, a}))
      fail("pin level");
  endtask : chk_pin
  // Counts cycles until the active-high push-pull pin rises
  task automatic chk_span(input int lo, input int hi);
    #1;
    n = 0;
    while (irq_pin_out !== 1'b1 && n < 99)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    n_checks++;
    if (n < lo || n > hi)
      fail($sformatf("pin rose after %0d cycles", n));
  endtask : chk_span
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #300000;
    fail("timeout");
    tally_and_finish();
  end
  initial
  begin
    st = 0;
    ie = 0;
    cf = 0;
    n = $urandom(32'hA20A798B);
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    wr(8'h50, -1);
    chk_reg(8'h50, ID);
    for (int k = 0; k < 4; k++)
      chk_reg(8'h54 + 8'(4 * k), 32'h0);
    for (int k = 0; k < 10; k++)
    begin
      i_host_bus_model.gap = k % 3;
      wr(8'h5C, $urandom);
      ev($urandom);
      chk_reg(8'h58, st);
      chk_reg(8'h54, cfx());
      wr(8'h58, $urandom);
      chk_reg(8'h58, st);
    end
    wr(8'h58, -1);
    wr(8'h5C, 32'h0002_0003);
    ev(1);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h54, 32'h100 | (k & 1) | ((k & 2) << 3));
      chk_pin(1);
      wr(8'h54, cf & 32'h11);
      chk_pin(0);
      chk_reg(8'h54, cfx());
    end
    wr(8'h58, -1);
    wr(8'h54, 32'h0200_0111);
    ev(1);
    chk_pin(1);
    wr(8'h58, 1);
    ev(2);
    chk_reg(8'h54, cfx() | 32'h2000);
    chk_span(2 * U - 5, 2 * U + 3);
    wr(8'h58, 2);
    ev(32'h0002_0000);
    chk_span(0, 3);
    wr(8'h58, 32'h0002_0000);
    ev(1);
    wr(8'h54, 32'h0000_0111);
    chk_span(0, 3);
    chk_reg(8'h54, cfx());
    wr(8'h58, -1);
    // Interval must already be non-zero when the clear strobe lands
    wr(8'h54, 32'h0100_0111);
    wr(8'h54, 32'h0100_4111);
    ev(1);
    chk_span(U - 4, U + 2);
    @(posedge clock);
    software_reset <= 1'b1;
    @(posedge clock);
    software_reset <= 1'b0;
    st = 0;
    ie = 0;
    cf &= 32'h11;
    chk_reg(8'h54, cf);
    chk_pin(0);
    tally_and_finish();
  end
endmodule : tb_host_interrupt_output_control
bind host_interrupt_output_control irq_out_checker i_irq_out_checker (
  .clock, .nrst, .software_reset, .interrupt_events, .reg_addr, .reg_write,
  .reg_read, .reg_wdata, .reg_rdata, .irq_pin_out, .irq_pin_oe);
`default_nettype wire
